// ---- src/wpd_top.sv ----
// Watchdog, HALT/STOP power-down control and reset-source flags.
// Assumes core strobes and opcode on mclk, and a raw recovery pin.
`timescale 1ns/100ps
`default_nettype none
module wpd_top
    import wpd_pkg::*;
#(
    parameter int         PRESCALE   = wpd_pkg::WPD_PRESCALE,
    parameter int         TICK_BASE  = wpd_pkg::WPD_TICK_BASE,
    parameter logic [7:0] WDT_OPCODE = wpd_pkg::WPD_OP_WDT_DFLT
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Core instruction stream
    input  wire logic        instr_strobe,
    input  wire logic [7:0]  instr_opcode,
    input  wire logic        irq_req,
    // Core control
    output logic             core_rst,
    output logic             cpu_clk_en,
    output logic             osc_en,
    output logic             pc_load,
    output logic [15:0]      pc_vector,
    // Recovery pin
    input  wire logic        port_b_bit_zero_n,
    input  wire logic        port_b_bit_zero_cfg
);
    import wpd_pkg::*;

    typedef struct packed {
        wpd_state_e  st;
        logic [6:0]  dly;
        logic [7:0]  ctrl;
        logic [1:0]  flg;
        logic        first_win;
        logic        core_rst;
        logic        clk_en;
        logic        osc_en;
        logic        pc_load;
        logic [15:0] pc_vec;
        logic        wait_r;
        logic [7:0]  rdata;
    } wpd_top_s;

    localparam wpd_top_s WPD_TOP_RST = '{
        st: wpd_st_por, dly: 7'h0, ctrl: WPD_CTRL_RST, flg: 2'h0, first_win: 1'b0,
        core_rst: 1'b1, clk_en: 1'b0, osc_en: 1'b1, pc_load: 1'b0,
        pc_vec: WPD_RESET_VECTOR, wait_r: 1'b1, rdata: 8'h0};

    wpd_top_s  q, d;
    wpd_wdt_if wdt_bus ();
    logic      pin_level;
    logic      bus_req;
    logic      wr_en;
    logic      is_halt;
    logic      is_stop;
    logic      is_svc;
    logic      wdt_fire;
    logic      wake_ok;
    logic [7:0] rd_mux;

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************

    // Recovery pin is asynchronous, so it is filtered before use
    wpd_sync #(
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .mclk  (mclk),
        .nrst  (nrst),
        .raw   (port_b_bit_zero_n),
        .level (pin_level)
    );

    wpd_wdog_cnt #(
        .PRESCALE  (PRESCALE),
        .TICK_BASE (TICK_BASE)
    ) u_wdog (
        .mclk (mclk),
        .nrst (nrst),
        .w    (wdt_bus.cnt)
    );

    // ****************************************************************
    // Decode
    // ****************************************************************

    // Instruction and event decode
    assign is_halt  = instr_strobe && (instr_opcode == WPD_OP_HALT);
    assign is_stop  = instr_strobe && (instr_opcode == WPD_OP_STOP);
    assign is_svc   = instr_strobe && (instr_opcode == WDT_OPCODE);
    assign wdt_fire = wdt_bus.timeout && ((q.st == wpd_st_run) || (q.st == wpd_st_halt));
    assign wake_ok  = !pin_level && port_b_bit_zero_cfg;

    // Counter steering; idle in reset phases and STOP, optional in HALT
    assign wdt_bus.run    = (q.st == wpd_st_run) ||
                            ((q.st == wpd_st_halt) && q.ctrl[WPD_CTRL_HALT_RUN]);
    assign wdt_bus.reload = is_svc && (q.st == wpd_st_run);
    assign wdt_bus.sel    = q.ctrl[WPD_CTRL_SEL_LSB +: 3];

    // Bus handshake: one wait cycle, then a one-cycle answer
    assign bus_req = avs_read || avs_write;
    assign wr_en   = avs_write && !q.wait_r && avs_byteenable[0];

    // Read mux; reserved and unmapped bits read as zero
    always_comb
    begin
        rd_mux = 8'h0;
        if (avs_address == WPD_ADDR_CTRL)
        begin
            rd_mux = {q.ctrl[7:3], 3'h0};
        end
        else if (avs_address == WPD_ADDR_CNT_LO)
        begin
            rd_mux = wdt_bus.count[7:0];
        end
        else if (avs_address == WPD_ADDR_CNT_HI)
        begin
            rd_mux = wdt_bus.count[15:8];
        end
        else if (avs_address == WPD_ADDR_FLAGS)
        begin
            rd_mux = {6'h0, q.flg};
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Bus, register writes, then mode sequencing; events are applied last
    always_comb
    begin
        d         = q;
        d.pc_load = 1'b0;
        d.wait_r  = 1'b1;
        if (bus_req && q.wait_r)
        begin
            d.wait_r = 1'b0;
            d.rdata  = rd_mux;
        end
        // Lock closes once the first instruction completes
        if (q.first_win && instr_strobe)
        begin
            d.first_win = 1'b0;
        end
        if (wr_en && (avs_address == WPD_ADDR_CTRL) && q.first_win)
        begin
            d.ctrl = {avs_writedata[7:3], 3'h0};
        end
        // A write of one clears a flag, and each STOP or timeout replaces both flags; reads never touch them
        if (wr_en && (avs_address == WPD_ADDR_FLAGS))
        begin
            d.flg = q.flg & ~avs_writedata[1:0];
        end
        case (q.st)
            wpd_st_por:
            begin
                d.core_rst = 1'b1;
                d.clk_en   = 1'b0;
                d.osc_en   = 1'b1;
                d.dly      = q.dly + 7'h1;
                if (q.dly == WPD_POR_CYCLES - 7'h1)
                begin
                    d.st  = wpd_st_start;
                    d.dly = 7'h0;
                end
            end
            wpd_st_start:
            begin
                d.dly = q.dly + 7'h1;
                if (q.dly == WPD_START_CYCLES - 7'h1)
                begin
                    d.st        = wpd_st_run;
                    d.dly       = 7'h0;
                    d.core_rst  = 1'b0;
                    d.clk_en    = 1'b1;
                    d.pc_load   = 1'b1;
                    d.first_win = 1'b1;
                end
            end
            wpd_st_run:
            begin
                d.core_rst = 1'b0;
                if (is_halt)
                begin
                    d.st     = wpd_st_halt;
                    d.clk_en = 1'b0;
                end
                else if (is_stop)
                begin
                    d.flg = WPD_SRC_STOP;
                    if (!q.ctrl[WPD_CTRL_STOP_DIS])
                    begin
                        d.st     = wpd_st_stop;
                        d.clk_en = 1'b0;
                        d.osc_en = 1'b0;
                    end
                end
            end
            wpd_st_halt:
            begin
                // Core runs the interrupt routine, then the next instruction
                if (irq_req)
                begin
                    d.st     = wpd_st_run;
                    d.clk_en = 1'b1;
                end
            end
            wpd_st_stop:
            begin
                // Only a recovery event or power-on reset leaves here
                if (wake_ok)
                begin
                    d.st       = wpd_st_por;
                    d.dly      = 7'h0;
                    d.osc_en   = 1'b1;
                    d.core_rst = 1'b1;
                end
            end
            default:
            begin
                d.st = wpd_st_por;
            end
        endcase
        // Terminal count: one reset cycle and a jump to the reset vector
        if (wdt_fire)
        begin
            d.st        = wpd_st_run;
            d.core_rst  = 1'b1;
            d.clk_en    = 1'b1;
            d.pc_load   = 1'b1;
            d.first_win = 1'b1;
            d.flg       = WPD_SRC_WDT;
        end
    end

    // State register; power-on reset clears flags and loads control defaults
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= WPD_TOP_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign avs_readdata    = {24'h0, q.rdata};
    assign avs_waitrequest = q.wait_r;
    assign core_rst        = q.core_rst;
    assign cpu_clk_en      = q.clk_en;
    assign osc_en          = q.osc_en;
    assign pc_load         = q.pc_load;
    assign pc_vector       = q.pc_vec;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    localparam int A_POR_M1 = 63;
    localparam int A_START  = 10;

    property p_por_delay;
        @(posedge mclk) disable iff (!nrst)
            $rose(q.st == wpd_st_por) |-> (q.core_rst throughout (##A_POR_M1 1'b1)) ##1 (q.st == wpd_st_start);
    endproperty
    a_por_delay: assert property (p_por_delay) else $error("power-on delay length wrong");

    property p_start_delay;
        @(posedge mclk) disable iff (!nrst)
            $rose(q.st == wpd_st_start) |-> ##A_START (q.st == wpd_st_run && q.pc_load && !q.core_rst);
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("start delay length wrong");

    property p_wdt_reset;
        @(posedge mclk) disable iff (!nrst)
            wdt_fire |=> (q.core_rst && q.pc_load && q.flg == WPD_SRC_WDT && q.pc_vec == WPD_RESET_VECTOR)
                         ##1 (!q.core_rst && !q.pc_load);
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset pulse wrong");

    property p_flag_read;
        @(posedge mclk) disable iff (!nrst)
            (avs_read && !q.wait_r && !wdt_fire && !is_stop) |=> $stable(q.flg);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("read changed a flag");

    property p_ctrl_lock;
        @(posedge mclk) disable iff (!nrst)
            (!q.first_win && !wdt_fire) |=> (q.ctrl == $past(q.ctrl));
    endproperty
    a_ctrl_lock: assert property (p_ctrl_lock) else $error("control changed after lock");

    property p_stop_nop;
        @(posedge mclk) disable iff (!nrst)
            (q.st == wpd_st_run && is_stop && q.ctrl[WPD_CTRL_STOP_DIS] && !wdt_fire)
            |=> (q.st == wpd_st_run && q.osc_en && q.flg == WPD_SRC_STOP);
    endproperty
    a_stop_nop: assert property (p_stop_nop) else $error("disabled stop did not act as no-op");

    property p_stop_enter;
        @(posedge mclk) disable iff (!nrst)
            (q.st == wpd_st_run && is_stop && !q.ctrl[WPD_CTRL_STOP_DIS] && !wdt_fire)
            |=> (q.st == wpd_st_stop && !q.osc_en && !q.clk_en && !wdt_bus.run);
    endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("stop entry wrong");

    property p_halt_enter;
        @(posedge mclk) disable iff (!nrst)
            (q.st == wpd_st_run && is_halt && !wdt_fire) |=> (q.st == wpd_st_halt && !q.clk_en && q.osc_en);
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("halt entry wrong");

    property p_halt_exit;
        @(posedge mclk) disable iff (!nrst)
            (q.st == wpd_st_halt && irq_req && !wdt_fire) |=> (q.st == wpd_st_run && q.clk_en && !q.core_rst);
    endproperty
    a_halt_exit: assert property (p_halt_exit) else $error("interrupt did not end halt");

    property p_halt_guard;
        @(posedge mclk) disable iff (!nrst)
            (q.st == wpd_st_halt && !q.ctrl[WPD_CTRL_HALT_RUN]) |-> !wdt_bus.run;
    endproperty
    a_halt_guard: assert property (p_halt_guard) else $error("watchdog ran in halt");

    property p_recover;
        @(posedge mclk) disable iff (!nrst)
            (q.st == wpd_st_stop && wake_ok) |=> (q.st == wpd_st_por && q.flg[WPD_FLAG_STOP] && $stable(q.ctrl));
    endproperty
    a_recover: assert property (p_recover) else $error("stop recovery wrong");

    property p_bus_answer;
        @(posedge mclk) disable iff (!nrst) (bus_req && q.wait_r) |=> !q.wait_r ##1 q.wait_r;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

    c_wdt_reset: cover property (@(posedge mclk) disable iff (!nrst) wdt_fire);
    c_halt_wake: cover property (@(posedge mclk) disable iff (!nrst) q.st == wpd_st_halt && irq_req);
    c_stop_wake: cover property (@(posedge mclk) disable iff (!nrst) q.st == wpd_st_stop && wake_ok);
    c_ctrl_wr:   cover property (@(posedge mclk) disable iff (!nrst)
                                 wr_en && avs_address == WPD_ADDR_CTRL && q.first_win);
endmodule : wpd_top
`default_nettype wire

// ---- common/wpd_pkg.sv ----
// Constants and types shared by the watchdog and power-down control block.
// Assumes a single 10 MHz crystal clock and an active-low asynchronous reset.
package wpd_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int          WPD_CLK_PERIOD_NS = 100;
    localparam int          WPD_PRESCALE      = 64;
    localparam int          WPD_LONG_MULT     = 4;
    localparam int          WPD_MIN_TMO_XTAL  = 65536;
    localparam int          WPD_TICK_BASE     = WPD_MIN_TMO_XTAL / WPD_PRESCALE;
    localparam logic [6:0]  WPD_POR_CYCLES    = 7'h40;
    localparam logic [6:0]  WPD_START_CYCLES  = 7'h0a;

    // ****************************************************************
    // Register map (word index on the bus)
    // ****************************************************************
    localparam logic [7:0]  WPD_ADDR_CTRL     = 8'hc1;
    localparam logic [7:0]  WPD_ADDR_CNT_LO   = 8'hc2;
    localparam logic [7:0]  WPD_ADDR_CNT_HI   = 8'hc3;
    localparam logic [7:0]  WPD_ADDR_FLAGS    = 8'hfc;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          WPD_CTRL_HALT_RUN = 7;
    localparam int          WPD_CTRL_SEL_LSB  = 4;
    localparam int          WPD_CTRL_STOP_DIS = 3;
    localparam int          WPD_FLAG_WDT      = 1;
    localparam int          WPD_FLAG_STOP     = 0;
    localparam logic [7:0]  WPD_CTRL_RST      = 8'h98;
    localparam logic [15:0] WPD_CNT_RST       = 16'hffff;
    localparam logic [15:0] WPD_RESET_VECTOR  = 16'h0020;
    localparam logic [1:0]  WPD_SRC_WDT       = 2'h2;
    localparam logic [1:0]  WPD_SRC_STOP      = 2'h1;

    // ****************************************************************
    // Opcodes and states
    // ****************************************************************
    localparam logic [7:0]  WPD_OP_HALT       = 8'h7f;
    localparam logic [7:0]  WPD_OP_STOP       = 8'h6f;
    localparam logic [7:0]  WPD_OP_WDT_DFLT   = 8'h5f;

    typedef enum logic [2:0] {
        wpd_st_por,
        wpd_st_start,
        wpd_st_run,
        wpd_st_halt,
        wpd_st_stop
    } wpd_state_e;

endpackage : wpd_pkg

// ---- common/wpd_wdt_if.sv ----
// Carrier between the control logic and the watchdog counter.
// Assumes both ends run on the same crystal clock.
`timescale 1ns/100ps
`default_nettype none
interface wpd_wdt_if;
    logic        run;
    logic        reload;
    logic [2:0]  sel;
    logic [15:0] count;
    logic        timeout;
    modport ctl (output run, reload, sel, input count, timeout);
    modport cnt (input run, reload, sel, output count, timeout);
endinterface : wpd_wdt_if
`default_nettype wire

// ---- src/wpd_sync.sv ----
// Three-stage pin synchroniser with a two-sample agreement filter.
// Assumes the raw input is asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module wpd_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // Pin side
    input  wire logic raw,
    output logic      level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } wpd_sync_s;

    wpd_sync_s q, d;

    // Stage one feeds stage two only; the filter looks at two and three
    always_comb
    begin
        d     = q;
        d.s1  = raw;
        d.s2  = q.s1;
        d.s3  = q.s2;
        if (q.s2 == q.s3)
        begin
            d.lvl = q.s3;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
        else
        begin
            q <= d;
        end
    end

    assign level = q.lvl;
endmodule : wpd_sync
`default_nettype wire

// ---- src/wpd_wdog_cnt.sv ----
// Watchdog down counter with prescaler and timeout-select reload table.
// Assumes run, reload and sel come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module wpd_wdog_cnt
    import wpd_pkg::*;
#(
    parameter int PRESCALE  = WPD_PRESCALE,
    parameter int TICK_BASE = WPD_TICK_BASE
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // Control side
    wpd_wdt_if.cnt    w
);
    typedef struct packed {
        logic [15:0] pre;
        logic [15:0] cnt;
        logic        tmo;
    } wpd_cnt_s;

    wpd_cnt_s    q, d;
    logic [15:0] lim;
    logic        fire;

    // Reload value in prescaled ticks; code 111 uses a longer prescale
    function automatic logic [15:0] wpd_reload(input logic [2:0] sel);
        logic [31:0] v;
        v = 32'(TICK_BASE) << 5;
        if (sel != 3'h7)
        begin
            v = 32'(TICK_BASE) << (sel - 3'h1);
        end
        if (sel == 3'h0)
        begin
            v = 32'h0;
        end
        return v[15:0] - 16'h1;
    endfunction : wpd_reload

    // Prescale limit and terminal count detection
    assign lim  = (w.sel == 3'h7) ? 16'(PRESCALE * WPD_LONG_MULT - 1) : 16'(PRESCALE - 1);
    assign fire = w.run && (w.sel != 3'h0) && (q.pre == lim) && (q.cnt == 16'h0);

    // Count, fire and reload; a timeout beats a same-cycle service
    always_comb
    begin
        d     = q;
        d.tmo = 1'b0;
        if (w.run && (w.sel != 3'h0))
        begin
            if (q.pre >= lim)
            begin
                d.pre = 16'h0;
                d.cnt = q.cnt - 16'h1;
                if (fire)
                begin
                    d.tmo = 1'b1;
                    d.cnt = wpd_reload(w.sel);
                end
            end
            else
            begin
                d.pre = q.pre + 16'h1;
            end
        end
        if (w.reload && !fire)
        begin
            d.cnt = wpd_reload(w.sel);
            d.pre = 16'h0;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '{16'h0, WPD_CNT_RST, 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign w.count   = q.cnt;
    assign w.timeout = q.tmo;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_race_fires;
        @(posedge mclk) disable iff (!nrst) (fire && w.reload) |=> w.timeout;
    endproperty
    a_race_fires: assert property (p_race_fires) else $error("service hid a timeout");

    property p_off_quiet;
        @(posedge mclk) disable iff (!nrst) (w.sel == 3'h0) |=> !w.timeout;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("timeout while disabled");

    property p_tick_rate;
        @(posedge mclk) disable iff (!nrst)
            (w.run && (w.sel != 3'h0) && !w.reload && (q.pre < lim))
            |=> ($stable(q.cnt) && (q.pre == $past(q.pre) + 16'h1));
    endproperty
    a_tick_rate: assert property (p_tick_rate) else $error("counter stepped too early");
endmodule : wpd_wdog_cnt
`default_nettype wire

// ---- tb/wpd_core_model.sv ----
// Model of the core software's instruction stream and the recovery pin driver.
// Assumes its tasks are entered just after a rising mclk edge.
`timescale 1ns/100ps
`default_nettype none
module wpd_core_model (
    // Clock
    input  wire logic mclk,
    // Core and pin side
    output logic       instr_strobe,
    output logic [7:0] instr_opcode,
    output logic       irq_req,
    output logic       pin_n,
    output logic       pin_cfg
);
    // Pin is an input with its special function before any STOP
    initial
    begin
        instr_strobe = 1'b0;
        instr_opcode = 8'h00;
        irq_req      = 1'b0;
        pin_n        = 1'b1;
        pin_cfg      = 1'b1;
    end
    // One instruction; an edge passes before the next may start
    task automatic exec(input logic [7:0] op);
        instr_strobe <= 1'b1;
        instr_opcode <= op;
        @(posedge mclk);
        instr_strobe <= 1'b0;
        @(posedge mclk);
    endtask : exec
    // Level interrupt request
    task automatic irq(input logic v);
        irq_req <= v;
        @(posedge mclk);
    endtask : irq
    // Pin configuration level from the port logic
    task automatic set_cfg(input logic v);
        pin_cfg <= v;
        @(posedge mclk);
    endtask : set_cfg
    // Low pulse longer than the pin filter needs
    task automatic wake();
        pin_n <= 1'b0;
        repeat (5) @(posedge mclk);
        pin_n <= 1'b1;
    endtask : wake
endmodule : wpd_core_model
`default_nettype wire

// ---- tb/tb_wpd_top.sv ----
// Self-checking bench for the watchdog and power-down block.
// Assumes short prescale and tick base so timeouts last a few hundred cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_wpd_top;
    import wpd_pkg::*;
    localparam logic [7:0] WDT_OP = WPD_OP_WDT_DFLT;
    logic mclk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic wait_r, c_rst, clk_en, osc, pcl, stb, irq, pn, cfg;
    logic [7:0] op, q;
    logic [15:0] vec;
    int num_errors = 0, n_compared = 0, n;
    always #50 mclk = ~mclk;
    wpd_top #(.PRESCALE(4), .TICK_BASE(64)) u_dut (.mclk(mclk), .nrst(nrst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdat),
        .avs_waitrequest(wait_r), .instr_strobe(stb), .instr_opcode(op), .irq_req(irq), .core_rst(c_rst),
        .cpu_clk_en(clk_en), .osc_en(osc), .pc_load(pcl), .pc_vector(vec), .port_b_bit_zero_n(pn),
        .port_b_bit_zero_cfg(cfg));
    wpd_core_model u_core (.mclk(mclk), .instr_strobe(stb), .instr_opcode(op), .irq_req(irq),
        .pin_n(pn), .pin_cfg(cfg));
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus transfer, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        adr <= a;
        wd <= {24'h0, d};
        wr <= w;
        rd <= ~w;
        do begin @(posedge mclk); k++; end while (wait_r !== 1'b0 && k < 50);
        chk({15'h0, wait_r}, 16'h0);
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk);
    endtask : acc
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk({8'h0, q}, {8'h0, e});
    endtask : rdc
    // Cycles until the core is handed the restart vector
    task automatic wait_pc();
        n = 0;
        while (pcl !== 1'b1 && n < 3000) begin @(posedge mclk); n++; end
        chk({15'h0, pcl}, 16'h1);
        chk(vec, WPD_RESET_VECTOR);
    endtask : wait_pc
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    // Hang guard, far beyond the few thousand cycles the tests need
    initial
    begin
        #2000000;
        num_errors++;
        give_verdict();
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        wait_pc();
        chk({15'h0, n == int'(WPD_POR_CYCLES) + int'(WPD_START_CYCLES) + 1}, 16'h1);
        rdc(WPD_ADDR_CTRL, 8'h98);
        rdc(WPD_ADDR_FLAGS, 8'h00);
        rdc(WPD_ADDR_CNT_HI, 8'hff);
        acc(1'b1, WPD_ADDR_CTRL, 8'h10);
        u_core.exec(WDT_OP);
        acc(1'b1, WPD_ADDR_CTRL, 8'h98);
        rdc(WPD_ADDR_CTRL, 8'h10);
        $display("test first-instruction window done");
        u_core.exec(WPD_OP_HALT);
        chk({14'h0, clk_en, osc}, 16'h1);
        repeat (400) @(posedge mclk);
        chk({14'h0, clk_en, c_rst}, 16'h0);
        u_core.irq(1'b1);
        u_core.irq(1'b0);
        chk({15'h0, clk_en}, 16'h1);
        $display("test halt done");
        u_core.exec(WDT_OP);
        wait_pc();
        chk({15'h0, n >= 240 && n <= 264}, 16'h1);
        chk({15'h0, c_rst}, 16'h1);
        rdc(WPD_ADDR_FLAGS, 8'h02);
        rdc(WPD_ADDR_FLAGS, 8'h02);
        acc(1'b1, WPD_ADDR_FLAGS, 8'h02);
        rdc(WPD_ADDR_FLAGS, 8'h00);
        $display("test timeout done");
        u_core.exec(WPD_OP_STOP);
        chk({14'h0, clk_en, osc}, 16'h0);
        repeat (600) @(posedge mclk);
        chk({15'h0, osc}, 16'h0);
        u_core.set_cfg(1'b0);
        u_core.wake();
        repeat (5) @(posedge mclk);
        chk({15'h0, osc}, 16'h0);
        u_core.set_cfg(1'b1);
        u_core.wake();
        wait_pc();
        chk({15'h0, n >= 66 && n <= 80}, 16'h1);
        rdc(WPD_ADDR_FLAGS, 8'h01);
        rdc(WPD_ADDR_CTRL, 8'h10);
        $display("test stop done");
        acc(1'b1, WPD_ADDR_FLAGS, 8'h01);
        acc(1'b1, WPD_ADDR_CTRL, 8'h08);
        u_core.exec(WPD_OP_STOP);
        chk({14'h0, clk_en, osc}, 16'h3);
        repeat (300) @(posedge mclk);
        rdc(WPD_ADDR_FLAGS, 8'h01);
        rdc(WPD_ADDR_CTRL, 8'h08);
        $display("test stop no-op done");
        give_verdict();
    end
endmodule : tb_wpd_top
`default_nettype wire
